// >>> logic/ang_autoneg.sv
// Contract
// - enabled: reset, power-down, link loss, restart start negotiation
// - after start, send link code word bursts
// - on match, keep sending with acknowledge set
// - changed partner abilities during ack restart
// - missing partner bursts restart negotiation
// - software sets four advertised ability bits
// - advertisement write alone never restarts
// - restart bit halts traffic, resumes after 1200 ms
// - link break restarts negotiation
// - disabled: force speed, duplex from control bits
// - enabled: ignore speed and duplex bits
// - show resolved speed and partner abilities
// - gigabit negotiation decides master or slave
// - runs without any MAC action
// - choose highest common ability
// - forced mode only 10 or 100
// - no pulses: parallel detect speed, half duplex
`timescale 1ns/10ps
`default_nettype none
module ang_autoneg
    import ang_pkg::*;
#(
    parameter int unsigned HOLD_CYC    = 32'(RESTART_HOLD_CYC),
    parameter int unsigned TIMEOUT_CYC = BURST_TIMEOUT_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        an_enable,       // negotiation enable control bit
    input  wire logic        restart_set,     // one-cycle write of restart bit
    input  wire logic        soft_reset,      // software reset pulse
    input  wire logic        power_down,      // level, negotiation restarts on exit
    input  wire logic [1:0]  speed_sel,       // forced speed select bits
    input  wire logic        duplex_sel,      // forced duplex bit, 1 = full
    input  wire logic        adv_wr,          // advertisement write strobe
    input  wire logic [3:0]  adv_wdata,       // 100fd,100,10fd,10
    input  wire logic        multi_port,      // local master/slave preference
    input  wire logic        link_up,         // link status from receiver
    input  wire logic        rx_lcw_valid,    // one-cycle: partner word received
    input  wire logic [15:0] rx_lcw,
    input  wire logic        pd_100_seen,     // legacy 100 Mb/s signalling seen
    input  wire logic        pd_10_seen,      // legacy normal link pulses seen
    output logic             tx_lcw_valid,    // request one burst
    output logic [15:0]      tx_lcw,
    output logic             traffic_halt,    // stops tx/rx during restart hold
    output logic             restart_bit,     // readback of restart control bit
    output logic [3:0]       adv_rdata,
    output logic [1:0]       speed_ind,
    output logic             duplex_full,
    output logic             an_complete,
    output logic [15:0]      partner_ability,
    output logic             partner_an_able,
    output logic             is_master,
    output logic             ms_fault
);
    ang_cnt_if cnt ();

    ang_timer u_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .cnt     (cnt)
    );

    ang_state_t       state_q, state_d;
    logic [7:0]       adv_q, adv_d;
    logic [15:0]      tx_q, tx_d;
    logic             txv_q, txv_d;
    logic             halt_q, halt_d;
    logic             rst_bit_q, rst_bit_d;
    logic [15:0]      last_rx_q, last_rx_d;
    logic [2:0]       match_q, match_d;
    logic [2:0]       sent_q, sent_d;
    logic [1:0]       spd_q, spd_d;
    logic             dup_q, dup_d;
    logic             done_q, done_d;
    logic [15:0]      lp_q, lp_d;
    logic             lp_able_q, lp_able_d;
    logic             mst_q, mst_d;
    logic             msf_q, msf_d;
    logic             pd_q, pd_d;
    logic             start_q;
    logic             link_q;
    logic [7:0]       common;
    logic             kick;
    logic             clr;

    // abilities both ends share
    // the highest of them is picked at completion
    assign common = adv_q & rx_lcw[LCW_ABIL_LSB +: LCW_ABIL_W];

    always_comb begin
        state_d   = state_q;
        adv_d     = adv_q;
        tx_d      = tx_q;
        txv_d     = 1'b0;
        halt_d    = halt_q;
        rst_bit_d = rst_bit_q;
        last_rx_d = last_rx_q;
        match_d   = match_q;
        sent_d    = sent_q;
        spd_d     = spd_q;
        dup_d     = dup_q;
        done_d    = done_q;
        lp_d      = lp_q;
        lp_able_d = lp_able_q;
        mst_d     = mst_q;
        msf_d     = msf_q;
        pd_d      = power_down;
        clr       = 1'b0;
        kick      = 1'b0;

        // advertised abilities; a write alone never kicks
        if (adv_wr) begin
            adv_d[3:0] = {adv_wdata[3], adv_wdata[2], adv_wdata[1], adv_wdata[0]};
        end

        if (start_q || soft_reset || (pd_q && !power_down) || (link_q && !link_up && done_q)) begin
            kick = 1'b1;
        end

        if (restart_set && an_enable) begin
            state_d   = ANG_HOLD;
            halt_d    = 1'b1;
            rst_bit_d = 1'b1;
            done_d    = 1'b0;
            clr       = 1'b1;
        end else if (!an_enable) begin
            state_d   = ANG_FORCED;
            // reserved code folds to 100 too, never an unsupported speed
            spd_d     = (speed_sel == SPD_10) ? SPD_10 : SPD_100;
            dup_d     = duplex_sel;
            done_d    = 1'b0;
            halt_d    = 1'b0;
            rst_bit_d = 1'b0;   // a pending restart is dropped with its hold
        end else if ((kick && state_q != ANG_HOLD) || state_q == ANG_FORCED || state_q == ANG_IDLE) begin
            // a start event inside the hold is ignored, the hold ends in a fresh start anyway
            state_d = ANG_ABIL;
            match_d = '0;
            sent_d  = '0;
            done_d  = 1'b0;
            clr     = 1'b1;
        end else begin
            case (state_q)
                ANG_HOLD: begin
                    if (cnt.count >= HOLD_CYC - 1) begin
                        rst_bit_d = 1'b0;
                        halt_d    = 1'b0;
                        state_d   = ANG_ABIL;
                        match_d   = '0;
                        sent_d    = '0;
                        clr       = 1'b1;
                    end
                end
                ANG_ABIL, ANG_ACK: begin
                    // bursts carry our word; ack once matched
                    tx_d = {1'b0, (state_q == ANG_ACK), multi_port, adv_q, LCW_SELECTOR};
                    if (rx_lcw_valid) begin
                        txv_d     = 1'b1;
                        clr       = 1'b1;
                        last_rx_d = rx_lcw;
                        if (state_q == ANG_ACK &&
                            rx_lcw[LCW_ABIL_LSB +: LCW_ABIL_W] != last_rx_q[LCW_ABIL_LSB +: LCW_ABIL_W]) begin
                            state_d = ANG_ABIL;
                            match_d = '0;
                            sent_d  = '0;
                        end else if (state_q == ANG_ABIL) begin
                            match_d = (rx_lcw == last_rx_q) ? match_q + 3'h1 : 3'h0;
                            if (match_q == 3'(ACK_MATCH_CNT - 1)) begin
                                state_d = ANG_ACK;
                            end
                        end else if (rx_lcw[LCW_ACK_BIT]) begin
                            sent_d = sent_q + 3'h1;
                            if (sent_q == 3'(ACK_SENT_CNT - 1)) begin
                                state_d   = ANG_DONE;
                                done_d    = 1'b1;
                                lp_d      = rx_lcw;
                                lp_able_d = 1'b1;
                                if (common[AB_1000FD]) begin
                                    spd_d = SPD_1000;
                                    dup_d = 1'b1;
                                end else if (common[AB_100FD] || common[AB_100HD]) begin
                                    spd_d = SPD_100;
                                    dup_d = common[AB_100FD];
                                end else begin
                                    spd_d = SPD_10;
                                    dup_d = common[AB_10FD];
                                end
                                mst_d = multi_port & ~rx_lcw[LCW_MS_BIT];
                                msf_d = 1'b0;
                            end
                        end
                    end else if (cnt.count >= TIMEOUT_CYC - 1) begin
                        clr = 1'b1;
                        if (pd_100_seen || pd_10_seen) begin
                            state_d   = ANG_DONE;
                            done_d    = 1'b1;
                            spd_d     = pd_100_seen ? SPD_100 : SPD_10;
                            dup_d     = 1'b0;
                            lp_able_d = 1'b0;
                            // legacy partner shown in the half duplex ability bits it was heard on
                            lp_d      = 16'(LCW_SELECTOR)
                                      | (16'(pd_100_seen) << (LCW_ABIL_LSB + AB_100HD))
                                      | (16'(pd_10_seen) << (LCW_ABIL_LSB + AB_10HD));
                            mst_d     = 1'b0;
                        end else begin
                            state_d = ANG_ABIL;
                            match_d = '0;
                            sent_d  = '0;
                        end
                    end
                end
                ANG_DONE: ;
                default: state_d = ANG_IDLE;
            endcase
        end
    end

    assign cnt.clear = clr;

    // all state held locally, no MAC handshake
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= ANG_IDLE;
            adv_q     <= ADV_RESET;
            tx_q      <= '0;
            txv_q     <= 1'b0;
            halt_q    <= 1'b0;
            rst_bit_q <= 1'b0;
            last_rx_q <= '0;
            match_q   <= '0;
            sent_q    <= '0;
            spd_q     <= SPD_10;
            dup_q     <= 1'b0;
            done_q    <= 1'b0;
            lp_q      <= '0;
            lp_able_q <= 1'b0;
            mst_q     <= 1'b0;
            msf_q     <= 1'b0;
            pd_q      <= 1'b0;
            start_q   <= 1'b1;   // hardware reset counts as a start event
            link_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            adv_q     <= adv_d;
            tx_q      <= tx_d;
            txv_q     <= txv_d;
            halt_q    <= halt_d;
            rst_bit_q <= rst_bit_d;
            last_rx_q <= last_rx_d;
            match_q   <= match_d;
            sent_q    <= sent_d;
            spd_q     <= spd_d;
            dup_q     <= dup_d;
            done_q    <= done_d;
            lp_q      <= lp_d;
            lp_able_q <= lp_able_d;
            mst_q     <= mst_d;
            msf_q     <= msf_d;
            pd_q      <= pd_d;
            start_q   <= 1'b0;
            link_q    <= link_up;
        end
    end

    assign tx_lcw_valid    = txv_q;
    assign tx_lcw          = tx_q;
    assign traffic_halt    = halt_q;
    assign restart_bit     = rst_bit_q;
    assign adv_rdata       = adv_q[3:0];
    assign speed_ind       = spd_q;
    assign duplex_full     = dup_q;
    assign an_complete     = done_q;
    assign partner_ability = lp_q;
    assign partner_an_able = lp_able_q;
    assign is_master       = mst_q;
    assign ms_fault        = msf_q;
endmodule : ang_autoneg
`default_nettype wire

// >>> logic/ang_pkg.sv
package ang_pkg;
    // link code word field layout (base page)
    localparam int unsigned LCW_W        = 16;
    localparam int unsigned LCW_ACK_BIT  = 14;
    localparam int unsigned LCW_SEL_LSB  = 0;
    localparam int unsigned LCW_SEL_W    = 5;
    localparam int unsigned LCW_ABIL_LSB = 5;
    localparam int unsigned LCW_ABIL_W   = 8;
    localparam int unsigned LCW_MS_BIT   = 13;   // multi-port preference carried in page
    localparam logic [4:0]  LCW_SELECTOR = 5'h01;
    // ability bit positions within the ability field
    localparam int unsigned AB_10HD  = 0;
    localparam int unsigned AB_10FD  = 1;
    localparam int unsigned AB_100HD = 2;
    localparam int unsigned AB_100FD = 3;
    localparam int unsigned AB_1000FD = 4;
    localparam logic [7:0]  ADV_RESET = 8'h1f;
    // resolved speed codes
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // timing
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned RESTART_HOLD_MS  = 1200;
    localparam longint unsigned RESTART_HOLD_CYC =
        longint'(RESTART_HOLD_MS) * 1000 * longint'(CLK_MHZ) * 1000 / 1000;
    localparam int unsigned BURST_TIMEOUT_DEF = 32'd3200000;   // 16 ms at 200 MHz
    localparam int unsigned ACK_MATCH_CNT     = 3;             // identical words before ack
    localparam int unsigned ACK_SENT_CNT      = 6;             // acked words to complete
    localparam int unsigned CNT_W             = 32;

    typedef enum logic [2:0] {
        ANG_IDLE   = 3'b000,
        ANG_HOLD   = 3'b001,
        ANG_ABIL   = 3'b010,
        ANG_ACK    = 3'b011,
        ANG_DONE   = 3'b100,
        ANG_FORCED = 3'b101
    } ang_state_t;
endpackage : ang_pkg

// >>> logic/ang_cnt_if.sv
`timescale 1ns/10ps
`default_nettype none
// carries the shared cycle counter between the negotiation logic and its timer
interface ang_cnt_if;
    logic        clear;
    logic [31:0] count;
    modport owner (output clear, input count);
    modport timer (input clear, output count);
endinterface : ang_cnt_if
`default_nettype wire

// >>> logic/ang_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ang_timer
    import ang_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    ang_cnt_if.timer  cnt
);
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // free-running count, saturates so a long wait never wraps
    always_comb begin
        if (cnt.clear) begin
            count_d = '0;
        end else if (&count_q) begin
            count_d = count_q;
        end else begin
            count_d = count_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign cnt.count = count_q;
endmodule : ang_timer
`default_nettype wire

// >>> sim/ang_autoneg_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ang_autoneg_checker
    import ang_pkg::*;
#(
    parameter int unsigned HOLD_CYC = 50
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic        an_enable,
    input wire logic        restart_set,
    input wire logic        soft_reset,
    input wire logic        power_down,
    input wire logic [1:0]  speed_sel,
    input wire logic        adv_wr,
    input wire logic [3:0]  adv_wdata,
    input wire logic        link_up,
    input wire logic        rx_lcw_valid,
    input wire logic        tx_lcw_valid,
    input wire logic [15:0] tx_lcw,
    input wire logic        traffic_halt,
    input wire logic        restart_bit,
    input wire logic [3:0]  adv_rdata,
    input wire logic [1:0]  speed_ind,
    input wire logic        an_complete
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [31:0] hcnt_q, hcnt_d;
    // length of the current halt, zero when idle
    always_comb hcnt_d = traffic_halt ? hcnt_q + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) hcnt_q <= 32'h0;
        else hcnt_q <= hcnt_d;
    end
    property p_rs; an_enable && restart_set && !traffic_halt |=> restart_bit && traffic_halt && !an_complete; endproperty
    a_rs: assert property (p_rs) else $error("restart not taken");
    property p_rs_off; !an_enable && restart_set && !restart_bit |=> !restart_bit; endproperty
    a_rs_off: assert property (p_rs_off) else $error("restart taken while disabled");
    property p_hmax; hcnt_q <= HOLD_CYC + 2; endproperty
    a_hmax: assert property (p_hmax) else $error("halt too long");
    property p_hmin; $fell(traffic_halt) |-> hcnt_q >= HOLD_CYC - 1; endproperty
    a_hmin: assert property (p_hmin) else $error("halt too short");
    property p_clr; $fell(traffic_halt) |-> !restart_bit; endproperty
    a_clr: assert property (p_clr) else $error("restart bit stuck");
    property p_quiet; traffic_halt [*2] |-> !tx_lcw_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("burst during halt");
    property p_txrx; tx_lcw_valid |-> $past(rx_lcw_valid) && tx_lcw[4:0] == LCW_SELECTOR; endproperty
    a_txrx: assert property (p_txrx) else $error("bad burst");
    property p_adv; adv_wr |=> adv_rdata == $past(adv_wdata); endproperty
    a_adv: assert property (p_adv) else $error("advert not stored");
    property p_keep;
        adv_wr && an_complete && link_up && an_enable && !restart_set && !soft_reset && !power_down |=> an_complete;
    endproperty
    a_keep: assert property (p_keep) else $error("advert write restarted");
    property p_frc; (!an_enable && $stable(speed_sel)) [*2] |-> speed_ind == ((speed_sel == SPD_10) ? SPD_10 : SPD_100);
    endproperty
    a_frc: assert property (p_frc) else $error("forced speed wrong");
    property p_loss; an_enable && an_complete && $fell(link_up) |=> !an_complete; endproperty
    a_loss: assert property (p_loss) else $error("link loss ignored");
    c_done: cover property ($rose(an_complete));
    c_halt: cover property ($rose(traffic_halt));
    c_frc: cover property (!an_enable && speed_sel == 2'h2);
endmodule : ang_autoneg_checker
bind ang_autoneg ang_autoneg_checker #(.HOLD_CYC(HOLD_CYC)) u_ang_autoneg_checker (
    .sys_clk(sys_clk), .resetn(resetn), .an_enable(an_enable), .restart_set(restart_set),
    .soft_reset(soft_reset), .power_down(power_down), .speed_sel(speed_sel), .adv_wr(adv_wr),
    .adv_wdata(adv_wdata), .link_up(link_up), .rx_lcw_valid(rx_lcw_valid), .tx_lcw_valid(tx_lcw_valid),
    .tx_lcw(tx_lcw), .traffic_halt(traffic_halt), .restart_bit(restart_bit), .adv_rdata(adv_rdata),
    .speed_ind(speed_ind), .an_complete(an_complete));
`default_nettype wire

// >>> sim/ang_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module ang_link_partner
    import ang_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic        go,
    input  wire logic        mut,
    input  wire logic [7:0]  abil,
    input  wire logic        tx_lcw_valid,
    input  wire logic [15:0] tx_lcw,
    output logic             rx_lcw_valid,
    output logic [15:0]      rx_lcw
);
    logic [2:0]  gap_q;
    logic [1:0]  same_q;
    logic [15:0] last_q;
    logic        ack_q;
    logic [15:0] word;
    // mut flips one ability bit to change the main content
    assign word = {1'b0, ack_q, 1'b0, abil ^ {7'h0, mut}, LCW_SELECTOR};
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            {gap_q, same_q, last_q, ack_q, rx_lcw_valid, rx_lcw} <= '0;
        end else begin
            gap_q <= gap_q + 3'h1;
            rx_lcw_valid <= go && gap_q == 3'h7;
            // idle line toggles so no stale word survives
            rx_lcw <= (go && gap_q == 3'h7) ? word : ~rx_lcw;
            if (!go) begin
                same_q <= 2'h0;
                ack_q <= 1'b0;
            end else if (tx_lcw_valid) begin
                last_q <= tx_lcw;
                same_q <= (tx_lcw[12:0] == last_q[12:0]) ? ((same_q == 2'h3) ? same_q : same_q + 2'h1) : 2'h0;
                ack_q <= tx_lcw[12:0] == last_q[12:0] && same_q >= 2'h2;
            end
        end
    end
endmodule : ang_link_partner
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ang_pkg::*;
    localparam int unsigned HC = 50;
    logic sys_clk = 0, resetn = 0, an_enable = 1, restart_set = 0, soft_reset = 0, power_down = 0;
    logic duplex_sel = 0, adv_wr = 0, multi_port = 0, link_up = 1, pd_100_seen = 0, pd_10_seen = 0;
    logic go = 0, mut = 0, ack_seen = 0, ack_clr = 0, rxv, txv, halt, rbit, dfull, done, pan, mst, msf;
    logic [1:0] speed_sel = 0, spd;
    logic [3:0] adv_wdata = 0, advr;
    logic [7:0] pab = 8'h0d;
    logic [15:0] rxw, txw, pa;
    int bad_count = 0, checked = 0, n;
    always #2.5 sys_clk = ~sys_clk;
    ang_autoneg #(.HOLD_CYC(HC), .TIMEOUT_CYC(200)) u_ang_autoneg (.sys_clk(sys_clk), .resetn(resetn),
        .an_enable(an_enable), .restart_set(restart_set), .soft_reset(soft_reset), .power_down(power_down),
        .speed_sel(speed_sel), .duplex_sel(duplex_sel), .adv_wr(adv_wr), .adv_wdata(adv_wdata),
        .multi_port(multi_port), .link_up(link_up), .rx_lcw_valid(rxv), .rx_lcw(rxw),
        .pd_100_seen(pd_100_seen), .pd_10_seen(pd_10_seen), .tx_lcw_valid(txv), .tx_lcw(txw),
        .traffic_halt(halt), .restart_bit(rbit), .adv_rdata(advr), .speed_ind(spd), .duplex_full(dfull),
        .an_complete(done), .partner_ability(pa), .partner_an_able(pan), .is_master(mst), .ms_fault(msf));
    ang_link_partner u_ang_link_partner (.sys_clk(sys_clk), .resetn(resetn), .go(go), .mut(mut), .abil(pab),
        .tx_lcw_valid(txv), .tx_lcw(txw), .rx_lcw_valid(rxv), .rx_lcw(rxw));
    // remember any acknowledged burst from the device; single driver, cleared on request
    always @(posedge sys_clk) ack_seen <= ack_clr ? 1'b0 : (ack_seen | (txv === 1'b1 && txw[14] === 1'b1));
    task summarize;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask : chk
    task step(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask : step
    function automatic logic sig(input int k);
        case (k)
            0: return done;
            1: return halt;
            2: return ack_seen;
            default: return txv;
        endcase
    endfunction : sig
    // bounded wait; running out ends the run
    task await(input int k, input logic v, input int lim);
        for (n = 0; n < lim && sig(k) !== v; n++) step(1);
        if (sig(k) !== v) begin
            $display("Error wait %0d expected %h seen %h", k, v, sig(k));
            bad_count++;
            summarize();
        end
    endtask : await
    task restart;
        restart_set = 1;
        step(1);
        restart_set = 0;
        chk("restart_bit", rbit, 1);
        chk("halt", halt, 1);
        chk("complete", done, 0);
        await(1, 0, 80);
        chk("hold", 16'(n), 16'(HC));
        chk("restart_clear", rbit, 0);
    endtask : restart
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1;
        step(1);
        chk("adv_reset", advr, 4'hf);
        chk("complete", done, 0);
        go = 1;
        await(0, 1, 400);
        chk("speed", spd, SPD_100);
        chk("duplex", dfull, 1);
        chk("ack_sent", ack_seen, 1);
        chk("partner", pa[12:5], pab);
        chk("an_able", pan, 1);
        $display("test base negotiation done");
        adv_wdata = 4'h1;
        adv_wr = 1;
        step(1);
        adv_wr = 0;
        chk("adv", advr, 4'h1);
        step(10);
        chk("complete", done, 1);
        restart();
        await(0, 1, 400);
        chk("speed", spd, SPD_10);
        chk("duplex", dfull, 0);
        link_up = 0;
        step(2);
        chk("complete", done, 0);
        link_up = 1;
        await(0, 1, 400);
        $display("test advert and link loss done");
        restart();
        ack_clr = 1;
        step(1);
        ack_clr = 0;
        await(2, 1, 400);
        mut = 1;
        step(1);
        // the burst answering the changed word still leaves from the ack phase
        await(3, 1, 40);
        step(1);
        await(3, 1, 40);
        chk("ack_dropped", txw[14], 0);
        mut = 0;
        await(0, 1, 600);
        $display("test content change done");
        restart();
        go = 0;
        pd_100_seen = 1;
        await(0, 1, 1000);
        chk("pd_speed", spd, SPD_100);
        chk("pd_duplex", dfull, 0);
        chk("pd_able", pan, 0);
        chk("pd_partner", pa, 16'h0081);
        pd_100_seen = 0;
        pd_10_seen = 1;
        restart();
        await(0, 1, 1000);
        chk("pd_speed", spd, SPD_10);
        chk("pd_partner", pa, 16'h0021);
        pd_10_seen = 0;
        go = 1;
        $display("test parallel detect done");
        pab = 8'h1f;
        multi_port = 1;
        soft_reset = 1;
        step(1);
        soft_reset = 0;
        step(1);
        chk("complete", done, 0);
        await(0, 1, 600);
        chk("speed", spd, SPD_1000);
        chk("master", mst, 1);
        chk("ms_fault", msf, 0);
        power_down = 1;
        step(3);
        power_down = 0;
        step(2);
        chk("complete", done, 0);
        $display("test gigabit and power down done");
        an_enable = 0;
        speed_sel = 2'h2;
        duplex_sel = 1;
        step(3);
        chk("forced_speed", spd, SPD_100);
        chk("forced_duplex", dfull, 1);
        speed_sel = 2'h3;
        step(2);
        chk("forced_speed", spd, SPD_100);
        speed_sel = 2'h0;
        duplex_sel = 0;
        restart_set = 1;
        step(1);
        restart_set = 0;
        step(2);
        chk("forced_speed", spd, SPD_10);
        chk("restart_bit", rbit, 0);
        $display("test forced mode done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
